// ---- core/umr_pkg.sv ----
// Package: register map, field positions, reset values and carrier types
package umr_pkg;
   // Register byte offsets on the APB side
   localparam logic [4:0] OFF_MODEM_STAT = 5'h00;   // Read-only modem status
   localparam logic [4:0] OFF_MODEM_CTRL = 5'h04;   // Modem control
   localparam logic [4:0] OFF_FIFO_CTRL  = 5'h08;   // FIFO control
   localparam logic [4:0] OFF_IRQ_STAT   = 5'h0c;   // Sticky event status, read-only
   localparam logic [4:0] OFF_IRQ_CLEAR  = 5'h10;   // Write one to clear status
   localparam logic [4:0] OFF_IRQ_EN     = 5'h14;   // Event enables
   localparam logic [4:0] OFF_RX_LEVEL   = 5'h18;   // Receive occupancy, read-only
   // Field positions
   localparam int MSR_RING_LEVEL = 6;               // Ring indication level
   localparam int MSR_RING_CHG   = 2;               // Ring trailing edge seen
   localparam int MCR_RTS        = 1;               // Request to send
   localparam int MCR_LOOP       = 4;               // Loopback
   localparam int MCR_AUTO_RTS   = 5;               // Automatic flow control
   localparam int FCR_FIFO_EN    = 0;               // FIFO mode
   localparam int FCR_DMA_MODE   = 3;               // Receive DMA mode select
   localparam int IRQ_MODEM      = 0;               // Modem status event
   localparam int IRQ_RX_REQ     = 1;               // Receive DMA request raised
   // Reset values
   localparam logic [7:0] RST_MCR = 8'h00;
   localparam logic [7:0] RST_FCR = 8'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;
   // Receive clock is sixteen times the bit rate
   localparam int RX_OVERSAMPLE = 16;
   // Receive DMA request states, Gray along the path
   typedef enum logic [1:0] {
      UMR_DMA_IDLE  = 2'b00,
      UMR_DMA_ARMED = 2'b01
   } umr_dma_state_t;
   // Parallel host read port
   typedef struct packed {
      logic       chipSelectA;      // Active high select
      logic       chipSelectB;      // Active high select
      logic       chipSelectLow_n;  // Active low select
      logic       hostReadStrobe;   // Active high read
      logic       hostReadStrobe_n; // Active low read
      logic [2:0] regIndex;         // Word index of register
   } umr_host_t;
endpackage : umr_pkg

// ---- core/umr_top.sv ----
// Modem signals, host read port and receive DMA request logic
//
// Function
// - Selected read strobe drives addressed register out
// - Status bit 6 shows ring indication
// - Status bit 2 flags ring trailing edge
// - Enabled ring edge raises interrupt
// - Control bit sets request to send active
// - Send request inactive: reset, loopback, bit cleared
// - Auto flow control drops request above threshold in FIFO mode
// - FIFO control bit 3 selects DMA mode
// - Non-FIFO mode always uses DMA mode 0
// - Mode 0: request low while characters remain
// - Mode 1: low from trigger or timeout until empty
// - Receiver timed from sixteen-times receive clock
// - Selected only with all three selects active
`timescale 1ns/1ps
`default_nettype none
module umr_top
   import umr_pkg::*;
#(
   parameter int LEVEL_W = 6                    // Width of receive occupancy count
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [4:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire umr_host_t          hostBus,
   output logic      [7:0]         hostData,
   output logic                    hostDataOe,
   input  wire logic               phoneCallIndication_n,
   input  wire logic               rxClock16,
   output logic                    rxBitTick,
   input  wire logic [LEVEL_W-1:0] rxLevel,
   input  wire logic               rxTriggerHit,
   input  wire logic               rxTimeout,
   output logic                    requestToSend_n,
   output logic                    receiveDmaRequest_n,
   output logic                    irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic rstMeta_q;                               // First stage, read only by second
   logic rstSync_q;                               // Design reset, active low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  mcr_q;                            // Modem control
   logic [7:0]  fcr_q;                            // FIFO control
   logic [1:0]  irqStat_q;                        // Sticky events
   logic [1:0]  irqEn_q;                          // Event enables
   logic        ringChg_q;                        // Ring edge flag
   logic        ringPrev_q;                       // Previous ring pin level
   logic        hostRdPrev_q;                     // Previous host read state
   logic [31:0] prdata_q;                         // Captured read data
   logic [7:0]  hostData_q;                       // Pin read data
   logic        rtsN_q;                           // Request to send pin
   logic        dmaReqN_q;                        // Receive request pin
   umr_dma_state_t dma_q;                         // Mode 1 request state
   umr_dma_state_t dma_d;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   // Read data is taken at setup, so side effects wait for the access edge
   wire apbSetup   = psel & ~penable;
   wire apbAccess  = psel & penable;
   wire [2:0] apbIdx = paddr[4:2];
   wire hitMsr    = (paddr == OFF_MODEM_STAT);
   wire hitMcr    = (paddr == OFF_MODEM_CTRL);
   wire hitFcr    = (paddr == OFF_FIFO_CTRL);
   wire hitIst    = (paddr == OFF_IRQ_STAT);
   wire hitIclr   = (paddr == OFF_IRQ_CLEAR);
   wire hitIen    = (paddr == OFF_IRQ_EN);
   wire hitLvl    = (paddr == OFF_RX_LEVEL);
   wire hitAny    = hitMsr | hitMcr | hitFcr | hitIst | hitIclr | hitIen | hitLvl;
   // Writes to read-only registers are refused as errors too
   wire wrLegal   = hitMcr | hitFcr | hitIclr | hitIen;
   wire apbErr    = ~hitAny | (pwrite & ~wrLegal);
   wire apbWrite  = apbAccess & pwrite & ~apbErr;
   wire wrMcr     = apbWrite & hitMcr;
   wire wrFcr     = apbWrite & hitFcr;
   wire wrIclr    = apbWrite & hitIclr;
   wire wrIen     = apbWrite & hitIen;

   // Zero wait states; read data captured in setup cycle
   assign pready  = apbAccess;
   assign pslverr = apbAccess & apbErr;
   assign prdata  = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Host pin read port
   wire hostSelected = hostBus.chipSelectA & hostBus.chipSelectB & ~hostBus.chipSelectLow_n;
   // Either strobe reads; the unused one is assumed parked inactive
   wire hostReading  = hostSelected & (hostBus.hostReadStrobe | ~hostBus.hostReadStrobe_n);
   wire hostRdStart  = hostReading & ~hostRdPrev_q;
   assign hostDataOe = hostReading;
   // Data follows the index every cycle, so it is valid one edge after the index settles
   assign hostData   = hostData_q;

   ////////////////////////////////////////////////////////////////////////////
   // Modem status
   wire ringLevel   = ~phoneCallIndication_n;
   // The edge is the pin returning high; the previous level resets high, so no false edge
   wire ringRise    = phoneCallIndication_n & ~ringPrev_q;
   wire msrReadApb  = apbAccess & ~pwrite & hitMsr;
   wire msrReadHost = hostRdStart & (hostBus.regIndex == OFF_MODEM_STAT[4:2]);
   // An APB read clears the flag only if its setup snapshot showed it, so an edge
   // landing between setup and access is still reported by the next read
   wire msrClear    = (msrReadApb & prdata_q[MSR_RING_CHG]) | msrReadHost;
   wire msrSetup    = apbSetup & (apbIdx == OFF_MODEM_STAT[4:2]);  // Status snapshot taken
   wire [7:0] msrVal = {1'b0, ringLevel, 3'h0, ringChg_q, 2'h0};

   // Register read mux shared by both ports
   function automatic logic [7:0] regRead(input logic [2:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         OFF_MODEM_STAT[4:2]: v = msrVal;
         OFF_MODEM_CTRL[4:2]: v = mcr_q;
         OFF_FIFO_CTRL[4:2]:  v = fcr_q;
         OFF_IRQ_STAT[4:2]:   v = {6'h00, irqStat_q};
         OFF_IRQ_EN[4:2]:     v = {6'h00, irqEn_q};
         OFF_RX_LEVEL[4:2]:   v = 8'(rxLevel);
         default:             v = 8'h00;  // Clear register and holes read zero
      endcase
      return v;
   endfunction : regRead

   ////////////////////////////////////////////////////////////////////////////
   // Receive bit tick from the sixteen-times clock
   logic       rxClkPrev_q;                       // Previous receive clock level
   logic [3:0] rxDiv_q;                           // Oversample counter
   wire rxClkRise = rxClock16 & ~rxClkPrev_q;
   wire rxDivWrap = rxClkRise & (rxDiv_q == 4'(RX_OVERSAMPLE - 1));
   // The receive clock is sampled as data: it must stay well below half the system clock
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         rxClkPrev_q <= 1'b0;
         rxDiv_q     <= 4'h0;
         rxBitTick   <= 1'b0;
      end else begin
         rxClkPrev_q <= rxClock16;
         rxBitTick   <= rxDivWrap;
         if (rxClkRise) begin
            rxDiv_q <= rxDiv_q + 4'h1;            // Wraps at sixteen
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and DMA request derivation
   wire fifoMode  = fcr_q[FCR_FIFO_EN];
   wire dmaMode1  = fifoMode & fcr_q[FCR_DMA_MODE];
   wire rxEmpty   = (rxLevel == '0);
   // Loopback keeps the pin parked; in FIFO mode auto flow drops it past the threshold
   wire rtsN_d    = mcr_q[MCR_LOOP] | ~mcr_q[MCR_RTS]
                  | (mcr_q[MCR_AUTO_RTS] & fifoMode & rxTriggerHit);
   wire dmaArm    = rxTriggerHit | rxTimeout;
   // The mode 1 state runs in mode 0 as well; only mode 1 lets it reach the pin

   // Mode 1 request: armed by trigger or timeout, released when empty
   always_comb begin
      dma_d = dma_q;
      unique case (dma_q)
         UMR_DMA_IDLE:  if (dmaArm & ~rxEmpty) dma_d = UMR_DMA_ARMED;
         UMR_DMA_ARMED: if (rxEmpty) dma_d = UMR_DMA_IDLE;
         default:       dma_d = UMR_DMA_IDLE;
      endcase
   end
   wire dmaReqN_d = dmaMode1 ? (dma_d != UMR_DMA_ARMED) : rxEmpty;
   wire reqRise   = ~dmaReqN_d & dmaReqN_q;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         mcr_q   <= RST_MCR;
         fcr_q   <= RST_FCR;
         irqEn_q <= RST_IRQ;
      end else begin
         // Only the low byte is kept, only the low two bits for the enables; the upper bits read back as zero
         if (wrMcr) mcr_q   <= pwdata[7:0];
         if (wrFcr) fcr_q   <= pwdata[7:0];
         if (wrIen) irqEn_q <= pwdata[1:0];
      end
   end

   // Event flags; a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         ringPrev_q <= 1'b1;
         ringChg_q  <= 1'b0;
         irqStat_q  <= RST_IRQ;
      end else begin
         ringPrev_q <= phoneCallIndication_n;
         if (ringRise) begin
            ringChg_q <= 1'b1;
         end else if (msrClear) begin
            ringChg_q <= 1'b0;
         end
         // Status sets whatever the enables hold, so software may poll with interrupts off
         irqStat_q <= (irqStat_q & ~({2{wrIclr}} & pwdata[1:0])) | {reqRise, ringRise};
      end
   end

   // Pins and read data
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         rtsN_q       <= 1'b1;
         dmaReqN_q    <= 1'b1;
         dma_q        <= UMR_DMA_IDLE;
         hostRdPrev_q <= 1'b0;
         hostData_q   <= 8'h00;
         prdata_q     <= 32'h0000_0000;
         irq          <= 1'b0;
      end else begin
         rtsN_q       <= rtsN_d;
         dmaReqN_q    <= dmaReqN_d;
         dma_q        <= dma_d;
         hostRdPrev_q <= hostReading;
         hostData_q   <= regRead(hostBus.regIndex);
         if (apbSetup) prdata_q <= {24'h00_0000, regRead(apbIdx)};
         irq          <= |(irqStat_q & irqEn_q);
      end
   end
   assign requestToSend_n     = rtsN_q;
   assign receiveDmaRequest_n = dmaReqN_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync_q);
   // Nothing is checked while the synchronised reset holds the block
   // Plain software request: bit set, no loopback, no automatic flow control
   wire rtsWanted = mcr_q[MCR_RTS] & ~mcr_q[MCR_LOOP] & ~mcr_q[MCR_AUTO_RTS];

   a_ring_edge_flag: assert property (ringRise |=> ringChg_q)
      else $error("Ring rising edge not flagged");
   a_ring_level_bit: assert property (msrSetup |=> prdata[MSR_RING_LEVEL] == !$past(phoneCallIndication_n))
      else $error("Ring level bit wrong");
   a_msr_read_clear: assert property (msrClear && !ringRise |=> !ringChg_q)
      else $error("Status read did not clear ring flag");
   a_ring_irq_raise: assert property (ringRise && irqEn_q[IRQ_MODEM] && !wrIen |=> ##1 irq)
      else $error("Enabled ring edge gave no interrupt");
   a_rts_parked: assert property (mcr_q[MCR_LOOP] || !mcr_q[MCR_RTS] |=> requestToSend_n)
      else $error("Request to send active while parked");
   a_rts_active: assert property (rtsWanted |=> !requestToSend_n)
      else $error("Request to send not driven active");
   a_auto_rts_drop: assert property (mcr_q[MCR_AUTO_RTS] && fifoMode && rxTriggerHit |=> requestToSend_n)
      else $error("Auto flow control failed to drop");
   a_mode0_request: assert property (!dmaMode1 |=> receiveDmaRequest_n == $past(rxEmpty))
      else $error("Mode 0 request does not follow occupancy");
   a_mode1_hold: assert property (dmaMode1 && dma_q == UMR_DMA_ARMED && !rxEmpty |=> !receiveDmaRequest_n)
      else $error("Mode 1 request released before empty");
   a_mode1_idle: assert property (dmaMode1 && !dmaArm && dma_q == UMR_DMA_IDLE |=> receiveDmaRequest_n)
      else $error("Mode 1 request without trigger");
   a_host_select: assert property (hostDataOe |-> hostBus.chipSelectA && hostBus.chipSelectB
                                   && !hostBus.chipSelectLow_n)
      else $error("Data driven while not selected");
   a_bit_tick: assert property (rxDivWrap |=> rxBitTick ##1 !rxBitTick)
      else $error("Bit tick not one cycle after wrap");
   a_msr_host_data: assert property (msrReadHost |=> hostData[MSR_RING_CHG] == $past(ringChg_q))
      else $error("Host status read lost the ring flag");
   a_ring_sticky: assert property (ringChg_q && !msrClear |=> ringChg_q)
      else $error("Ring flag dropped without a status read");
   a_irq_w1c: assert property (wrIclr && pwdata[IRQ_MODEM] && !ringRise |=> !irqStat_q[IRQ_MODEM])
      else $error("Ring status not cleared by write");
   a_irq_masked: assert property (!irqEn_q[IRQ_MODEM] && !irqEn_q[IRQ_RX_REQ] |=> !irq)
      else $error("Interrupt raised with all events disabled");
   a_mode1_arm: assert property (dmaMode1 && dmaArm && !rxEmpty |=> !receiveDmaRequest_n)
      else $error("Mode 1 request not raised at trigger");
   a_mode1_release: assert property (dmaMode1 && rxEmpty |=> receiveDmaRequest_n)
      else $error("Mode 1 request held while empty");

   // Main scenarios
   c_ring_irq:   cover property (ringRise ##[1:4] irq);
   c_mode1_burst: cover property (dmaMode1 && rxTriggerHit ##1 !receiveDmaRequest_n ##[1:50] receiveDmaRequest_n);
   c_host_read:  cover property (hostRdStart && msrReadHost && ringChg_q);
   c_apb_error:  cover property (pslverr);
   c_fifo_mode0: cover property (fifoMode && !dmaMode1 && !receiveDmaRequest_n);
endmodule : umr_top
`default_nettype wire

// ---- verification/umr_far_model.sv ----
// Far-side model: receive FIFO occupancy, DMA controller drain and receive baud clock
`timescale 1ns/1ps
`default_nettype none
module umr_far_model
   import umr_pkg::*;
#(
   parameter int LEVEL_W = 6,                    // Occupancy count width
   parameter int TRIG    = 4                     // Receive trigger level
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               fillPulse,    // One character arrives
   input  wire logic               drainEn,      // DMA controller active
   input  wire logic               burstMode,    // Back-to-back reads
   input  wire logic               dmaReq_n,     // Request from the block
   output logic      [LEVEL_W-1:0] rxLevel,      // Characters held
   output logic                    rxTriggerHit, // At or above trigger
   output logic                    rxClock16     // Sixteen-times baud clock
);
   ////////////////////////////////////////////////////////////////////////////////
   logic       gap_q;                            // Leaves a host slot between single reads
   logic [1:0] div_q;                            // Baud divider, four system clocks a period
   logic       take;                             // A character is read this cycle
   // Single mode reads every other cycle, burst mode every cycle
   assign take         = drainEn & ~dmaReq_n & (rxLevel != '0) & (burstMode | gap_q);
   assign rxTriggerHit = (rxLevel >= LEVEL_W'(TRIG));
   // Kept well below half the system clock so the block can sample it
   assign rxClock16    = div_q[1];
   ////////////////////////////////////////////////////////////////////////////////
   // Occupancy, slot and divider state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxLevel <= '0;
         gap_q   <= 1'b0;
         div_q   <= 2'h0;
      end else begin
         gap_q <= ~gap_q;
         div_q <= div_q + 2'h1;
         if (fillPulse) begin
            rxLevel <= rxLevel + 1'b1;
         end else if (take) begin
            rxLevel <= rxLevel - 1'b1;
         end
      end
   end
endmodule : umr_far_model
`default_nettype wire

// ---- verification/umr_top_tb_top.sv ----
// Self-checking bench: APB and host reads, ring events, send request, receive DMA request
`timescale 1ns/1ps
`default_nettype none
module umr_top_tb_top;
   import umr_pkg::*;
   localparam int LW = 6;                        // Occupancy width
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, hostDataOe, phoneCallIndication_n;
   logic rxClock16, rxBitTick, rxTriggerHit, rxTimeout, requestToSend_n, receiveDmaRequest_n, irq;
   logic fillPulse, drainEn, burstMode;          // Far-side controls
   logic [4:0]    paddr;
   logic [31:0]   pwdata, prdata, seed;
   logic [7:0]    hostData, v;
   logic [LW-1:0] rxLevel;
   umr_host_t     hostBus;
   logic [33:0]   noteQ[$];                      // Expected APB results, oldest first
   logic [33:0]   note;
   int            errorCnt, samplesChecked, n;
   logic [4:0]    offs[7] = '{OFF_MODEM_CTRL, OFF_FIFO_CTRL, OFF_IRQ_STAT, OFF_IRQ_CLEAR,
                              OFF_IRQ_EN, OFF_MODEM_STAT, OFF_RX_LEVEL};
   umr_top #(.LEVEL_W(LW)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostBus(hostBus),
      .hostData(hostData), .hostDataOe(hostDataOe), .phoneCallIndication_n(phoneCallIndication_n),
      .rxClock16(rxClock16), .rxBitTick(rxBitTick), .rxLevel(rxLevel), .rxTriggerHit(rxTriggerHit),
      .rxTimeout(rxTimeout), .requestToSend_n(requestToSend_n), .receiveDmaRequest_n(receiveDmaRequest_n),
      .irq(irq));
   umr_far_model #(.LEVEL_W(LW), .TRIG(4)) farEnd (.clk(clk), .rst_n(rst_n), .fillPulse(fillPulse),
      .drainEn(drainEn), .burstMode(burstMode), .dmaReq_n(receiveDmaRequest_n), .rxLevel(rxLevel),
      .rxTriggerHit(rxTriggerHit), .rxClock16(rxClock16));
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run, the only exit
   task automatic endSim();
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : endSim
   // One comparison, counted
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Pseudo-random source
   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsrNext
   // One APB transfer; the result is noted for the monitor
   task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic err,
                      input logic [31:0] ed);
      int k;
      noteQ.push_back({wr, err, ed});
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      // Held until pready is seen at a rising edge, bounded
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         errorCnt++;
         endSim();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Host pin read; only one strobe is used, the other parked inactive
   task automatic hostRead(input logic [2:0] sel, input logic lowStrobe, input logic [2:0] idx,
                           input logic oe, input logic [7:0] exp);
      @(posedge clk);
      hostBus <= '{sel[2], sel[1], sel[0], ~lowStrobe, ~lowStrobe, idx};
      #1 check(hostDataOe, oe);
      @(posedge clk);
      #1 if (oe) check(hostData, exp);
      @(posedge clk);
      hostBus <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0};
   endtask : hostRead
   // Bounded wait for a bit tick or an occupancy value
   task automatic waitUntil(input logic tick, input logic [LW-1:0] lvl, output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (!(tick ? rxBitTick === 1'b1 : rxLevel === lvl) && k < 400);
      if (k >= 400) begin
         errorCnt++;
         endSim();
      end
   endtask : waitUntil
   // Settle two edges, then compare an output
   task automatic late(input logic seen_sel, input logic exp);
      repeat (2) @(posedge clk);
      #1 check(seen_sel ? receiveDmaRequest_n : requestToSend_n, exp);
   endtask : late
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and APB result monitor
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (noteQ.size() == 0) check(32'h1, 32'h0);
         else begin
            note = noteQ.pop_front();
            check({31'h0, pslverr}, {31'h0, note[32]});
            if (!note[33]) check(prdata, note[31:0]);
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, fillPulse, drainEn, burstMode, rxTimeout} = '0;
      {paddr, pwdata, errorCnt, samplesChecked} = '0;
      phoneCallIndication_n = 1'b1;
      hostBus = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0};
      seed = 32'h0afa;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check(requestToSend_n, 32'h1);
      foreach (offs[i]) apb(1'b0, offs[i], 32'h0, 1'b0, 32'h0);
      foreach (offs[i]) if (i >= 2 && i != 3 && i != 4) apb(1'b1, offs[i], seed, 1'b1, 32'h0);
      apb(1'b1, 5'h1c, lfsrNext(seed), 1'b1, 32'h0);
      for (int k = 0; k < 7; k++) begin
         seed = lfsrNext(seed);
         v = (k == 5) ? 8'h12 : (k == 6) ? 8'h02 : seed[7:0];
         apb(1'b1, OFF_MODEM_CTRL, {24'h0, v}, 1'b0, 32'h0);
         late(1'b0, ~(v[1] & ~v[4]));
      end
      for (int k = 0; k < 3; k++) hostRead(3'b110 ^ (3'b001 << k), k[0], 3'h1, 1'b0, 8'h0);
      hostRead(3'b110, 1'b1, 3'h1, 1'b1, 8'h02);
      apb(1'b1, OFF_IRQ_EN, 32'h1, 1'b0, 32'h0);
      @(posedge clk) phoneCallIndication_n <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, OFF_MODEM_STAT, 32'h0, 1'b0, 32'h40);
      #1 check(irq, 32'h0);
      @(posedge clk) phoneCallIndication_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check(irq, 32'h1);
      apb(1'b0, OFF_MODEM_STAT, 32'h0, 1'b0, 32'h04);
      apb(1'b0, OFF_MODEM_STAT, 32'h0, 1'b0, 32'h00);
      apb(1'b0, OFF_IRQ_STAT, 32'h0, 1'b0, 32'h01);
      apb(1'b1, OFF_IRQ_CLEAR, 32'h1, 1'b0, 32'h0);
      apb(1'b1, OFF_IRQ_EN, 32'h0, 1'b0, 32'h0);
      #1 check(irq, 32'h0);
      @(posedge clk) phoneCallIndication_n <= 1'b0;
      @(posedge clk) phoneCallIndication_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check(irq, 32'h0);
      hostRead(3'b110, 1'b0, 3'h0, 1'b1, 8'h04);
      apb(1'b0, OFF_MODEM_STAT, 32'h0, 1'b0, 32'h00);
      apb(1'b1, OFF_IRQ_CLEAR, 32'h1, 1'b0, 32'h0);
      waitUntil(1'b1, '0, n);
      waitUntil(1'b1, '0, n);
      check(n, 32'd64);
      // Compatibility mode ignores the mode select bit
      apb(1'b1, OFF_FIFO_CTRL, 32'h08, 1'b0, 32'h0);
      @(posedge clk) fillPulse <= 1'b1;
      @(posedge clk) fillPulse <= 1'b0;
      late(1'b1, 1'b0);
      apb(1'b0, OFF_RX_LEVEL, 32'h0, 1'b0, 32'h1);
      @(posedge clk) drainEn <= 1'b1;
      waitUntil(1'b0, '0, n);
      late(1'b1, 1'b1);
      @(posedge clk) drainEn <= 1'b0;
      apb(1'b1, OFF_FIFO_CTRL, 32'h09, 1'b0, 32'h0);
      repeat (3) begin
         @(posedge clk) fillPulse <= 1'b1;
         @(posedge clk) fillPulse <= 1'b0;
      end
      late(1'b1, 1'b1);
      @(posedge clk) fillPulse <= 1'b1;
      @(posedge clk) fillPulse <= 1'b0;
      late(1'b1, 1'b0);
      apb(1'b0, OFF_IRQ_STAT, 32'h0, 1'b0, 32'h02);
      apb(1'b1, OFF_MODEM_CTRL, 32'h22, 1'b0, 32'h0);
      late(1'b0, 1'b1);
      @(posedge clk) {drainEn, burstMode} <= 2'b11;
      waitUntil(1'b0, LW'(2), n);
      check(receiveDmaRequest_n, 32'h0);
      waitUntil(1'b0, '0, n);
      late(1'b1, 1'b1);
      #1 check(requestToSend_n, 32'h0);
      @(posedge clk) {drainEn, fillPulse} <= 2'b01;
      @(posedge clk) fillPulse <= 1'b0;
      late(1'b1, 1'b1);
      @(posedge clk) rxTimeout <= 1'b1;
      @(posedge clk) rxTimeout <= 1'b0;
      late(1'b1, 1'b0);
      // FIFO mode with mode 0 selected: one character is enough to request
      @(posedge clk) {drainEn, burstMode} <= 2'b10;
      waitUntil(1'b0, '0, n);
      late(1'b1, 1'b1);
      @(posedge clk) drainEn <= 1'b0;
      apb(1'b1, OFF_FIFO_CTRL, 32'h01, 1'b0, 32'h0);
      @(posedge clk) fillPulse <= 1'b1;
      @(posedge clk) fillPulse <= 1'b0;
      late(1'b1, 1'b0);
      endSim();
   end
endmodule : umr_top_tb_top
`default_nettype wire
